// [logic/sccu_top.sv]
// Sixteen channel capture/compare unit with two time bases and an AHB-Lite slave.
//
// What this block does
// - Sixteen channels; staggered option gives prescaled sources one count slot every eighth clock.
// - Two 16-bit time bases with own reload registers.
// - Count source: prescaled clock or neighbour timer overflow.
// - External count input can advance a time base.
// - Each channel picks time base and capture/compare.
// - One pin per channel, input or output.
// - Capture latches assigned time base on pin event.
// - Each capture raises that channel's interrupt flag.
// - Capture edge: rising, falling or both.
// - Compare modes match register against time base.
// - Mode zero: interrupt per match, pin untouched.
// - Mode one: pin toggles on every match.
// - Mode two: one match interrupt per period.
// - Mode three: high on match, low on overflow.
// - Paired mode: two registers toggle one pin.
// - One-shot option stops a channel after one match.
//
// Local design decisions: the address map and the AHB-Lite register port.
module sccu_top
  import sccu_pkg::*;
#(
  parameter int NCH = SCCU_NCH // Channel count, fixed by the register map.
) (
  input wire logic clk_in, // System clock, 40 MHz.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  input wire logic hsel_in, // AHB slave select.
  input wire logic [31:0] haddr_in, // AHB address.
  input wire logic [1:0] htrans_in, // AHB transfer type.
  input wire logic hwrite_in, // AHB write flag.
  input wire logic [2:0] hsize_in, // AHB size, only words are used.
  input wire logic [31:0] hwdata_in, // AHB write data.
  input wire logic hready_in, // AHB bus ready.
  output logic [31:0] hrdata_out, // AHB read data.
  output logic hreadyout_out, // AHB slave ready.
  output logic hresp_out, // AHB response, always OKAY.
  input wire logic neighbour_ovf_in, // Overflow pulse of the neighbour timer.
  input wire logic ext_count_in, // External count input, counts rising edges.
  input wire logic [NCH-1:0] pin_in, // Channel pin levels.
  output logic [NCH-1:0] pin_out, // Channel pin drive values.
  output logic [NCH-1:0] pin_oe_out, // Channel pin output enables.
  output logic irq_out // Level interrupt, any unmasked flag set.
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and declarations.

  logic [1:0] rst_sync; // Reset release chain.
  wire rst_n = rst_sync[1]; // Released reset used by all logic.
  logic [SCCU_NTB-1:0] run; // Time base run enables.
  logic stag; // Staggered option.
  logic [2:0] src_sel [SCCU_NTB]; // Count source per time base.
  logic [15:0] tb [SCCU_NTB]; // Time base counters.
  logic [15:0] rel [SCCU_NTB]; // Reload registers.
  logic [SCCU_NTB-1:0] tick_d; // Count update seen last clock.
  logic [4:0] presc; // Free-running prescaler.
  logic [2:0] phase; // Stagger slot counter.
  logic ext_q; // Previous external count level.
  logic [15:0] val [NCH]; // Channel capture/compare registers.
  sccu_cfg_type cfg [NCH]; // Channel configurations.
  logic [NCH-1:0] pin_q; // Previous pin levels.
  logic [NCH-1:0] armed; // Once-per-period gate.
  logic [NCH-1:0] done; // One-shot finished.
  logic [17:0] stat; // Sticky event flags.
  logic [17:0] mask; // Interrupt enables.
  logic wr_pend; // Write data phase pending.
  logic [7:0] wr_ofs; // Offset of the pending write.

  // Selects the count pulse for one time base.
  function automatic logic src_tick(input logic [2:0] sel, input logic [4:0] pc,
                                    input logic nb, input logic ext);
    logic [4:0] m;
    m = 5'((6'h01 << sel) - 6'h01);
    if (sel == SCCU_SRC_NEIGH) begin
      return nb;
    end else if (sel == SCCU_SRC_EXT) begin
      return ext;
    end
    return (pc & m) == m;
  endfunction : src_tick

  // True for any mode that compares against its time base.
  function automatic logic is_cmp(input sccu_mode_type md);
    return md inside {SCCU_CMP0, SCCU_CMP1, SCCU_CMP2, SCCU_CMP3, SCCU_DBL};
  endfunction : is_cmp

  // Two flops release the reset; the first feeds only the second.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // An address phase is taken only when the bus is ready.
  wire ap_take = hsel_in && hready_in && htrans_in[1];
  // Only address bits 7:0 decode, so the map repeats every 256 bytes.
  wire [7:0] rd_ofs = haddr_in[7:0];
  wire we_ctrl = wr_pend && wr_ofs == SCCU_CTRL_OFS;
  wire we_stat = wr_pend && wr_ofs == SCCU_STAT_OFS;
  wire we_mask = wr_pend && wr_ofs == SCCU_MASK_OFS;
  wire [15:0] wdata16 = hwdata_in[15:0];

  // Read multiplexer; unmapped offsets return zero.
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_ofs)
      SCCU_CTRL_OFS: begin
        rd_data[SCCU_RUN_POS +: 2] = run;
        rd_data[SCCU_STAG_POS] = stag;
        rd_data[SCCU_SEL_A_POS +: 3] = src_sel[0];
        rd_data[SCCU_SEL_B_POS +: 3] = src_sel[1];
      end
      SCCU_TB_OFS: rd_data[15:0] = tb[0];
      SCCU_TB_OFS + 8'h04: rd_data[15:0] = tb[1];
      SCCU_REL_OFS: rd_data[15:0] = rel[0];
      SCCU_REL_OFS + 8'h04: rd_data[15:0] = rel[1];
      SCCU_STAT_OFS: rd_data[17:0] = stat;
      SCCU_MASK_OFS: rd_data[17:0] = mask;
      default: begin
        if (rd_ofs[1:0] == 2'h0 && rd_ofs[7:6] == SCCU_VAL_WIN) begin
          rd_data[15:0] = val[rd_ofs[5:2]];
        end else if (rd_ofs[1:0] == 2'h0 && rd_ofs[7:6] == SCCU_CFG_WIN) begin
          rd_data[6:0] = cfg[rd_ofs[5:2]];
        end
      end
    endcase
  end

  // Read data is fetched in the address phase, so the slave never waits.
  // A read right after a write to the same register shows the old value.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      wr_pend <= ap_take && hwrite_in;
      wr_ofs <= ap_take ? rd_ofs : wr_ofs;
      hrdata_out <= (ap_take && !hwrite_in) ? rd_data : 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time bases.

  // Neighbour and external pulses bypass the stagger slot, since a pulse
  // that falls outside the slot would otherwise be lost.
  wire ext_rise = ext_count_in && !ext_q;
  wire slot = !stag || phase == SCCU_STAG_LAST;
  logic [SCCU_NTB-1:0] tick; // Count update this clock.
  logic [SCCU_NTB-1:0] ovf; // Overflow this clock.
  for (genvar t = 0; t < SCCU_NTB; t++) begin : g_tb
    wire prescaled = src_sel[t] < SCCU_SRC_NEIGH;
    wire pulse = src_tick(src_sel[t], presc, neighbour_ovf_in, ext_rise);
    assign tick[t] = run[t] && pulse && (slot || !prescaled);
    assign ovf[t] = tick[t] && tb[t] == SCCU_CNT_TOP;
  end

  // Prescaler, stagger slot and control register.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      presc <= 5'h00;
      phase <= 3'h0;
      ext_q <= 1'b0;
      run <= '0;
      stag <= 1'b0;
      src_sel[0] <= SCCU_SEL_RST;
      src_sel[1] <= SCCU_SEL_RST;
    end else begin
      presc <= (slot ? presc + 5'h01 : presc); // Prescaler advances in slots only.
      phase <= phase + 3'h1;
      ext_q <= ext_count_in;
      if (we_ctrl) begin
        run <= hwdata_in[SCCU_RUN_POS +: 2];
        stag <= hwdata_in[SCCU_STAG_POS];
        src_sel[0] <= hwdata_in[SCCU_SEL_A_POS +: 3];
        src_sel[1] <= hwdata_in[SCCU_SEL_B_POS +: 3];
      end
    end
  end

  // Counters and reloads; a software write takes the place of a count.
  // A count that fires in the clock of such a write is lost, so software that
  // needs an exact phase should stop the time base before loading it.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < SCCU_NTB; t++) begin
        tb[t] <= SCCU_CNT_RST;
        rel[t] <= SCCU_CNT_RST;
      end
      tick_d <= '0;
    end else begin
      tick_d <= tick;
      for (int t = 0; t < SCCU_NTB; t++) begin
        if (wr_pend && wr_ofs == SCCU_REL_OFS + 8'(4 * t)) begin
          rel[t] <= wdata16;
        end
        if (wr_pend && wr_ofs == SCCU_TB_OFS + 8'(4 * t)) begin
          tb[t] <= wdata16;
        end else if (ovf[t]) begin
          tb[t] <= rel[t];
        end else if (tick[t]) begin
          tb[t] <= tb[t] + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels.

  logic [NCH-1:0] match; // Compare match this clock.
  logic [NCH-1:0] cap_ev; // Capture event this clock.
  logic [NCH-1:0] cmp_en; // Channel compares.
  logic [NCH-1:0] we_val; // Value register write.
  logic [NCH-1:0] we_cfg; // Config register write.
  logic [NCH-1:0] tog; // Pin toggle request.
  logic [NCH-1:0] ovf_ch; // Overflow of the channel's time base.
  logic [NCH-1:0] drive; // Channel drives its pin.
  logic [15:0] tb_ch [NCH]; // Assigned time base value.
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    wire sel = cfg[i].tb_sel;
    wire once = cfg[i].mode inside {SCCU_CMP2, SCCU_CMP3};
    wire rise = pin_in[i] && !pin_q[i];
    wire fall = !pin_in[i] && pin_q[i];
    wire [1:0] es = cfg[i].edge_sel;
    assign tb_ch[i] = tb[sel];
    assign ovf_ch[i] = ovf[sel];
    assign we_val[i] = wr_pend && wr_ofs[7:6] == SCCU_VAL_WIN && wr_ofs[5:2] == 4'(i);
    assign we_cfg[i] = wr_pend && wr_ofs[7:6] == SCCU_CFG_WIN && wr_ofs[5:2] == 4'(i);
    // The high partner of a paired channel compares on its own register.
    if (i >= SCCU_HALF) begin : g_hi
      assign cmp_en[i] = is_cmp(cfg[i].mode) || cfg[i - SCCU_HALF].mode == SCCU_DBL;
      assign tog[i] = cfg[i].mode == SCCU_CMP1 && match[i];
    end else begin : g_lo
      assign cmp_en[i] = is_cmp(cfg[i].mode);
      assign tog[i] = (cfg[i].mode == SCCU_CMP1 && match[i])
        || (cfg[i].mode == SCCU_DBL && (match[i] ^ match[i + SCCU_HALF]));
    end
    // Matches are looked for only right after the count moved.
    // A value written equal to the present count therefore waits until the
    // count comes round again; a stopped time base never matches.
    assign match[i] = cmp_en[i] && tick_d[sel] && tb_ch[i] == val[i]
      && !done[i] && (armed[i] || !once);
    assign cap_ev[i] = cfg[i].mode == SCCU_CAPT
      && ((es[0] && rise) || (es[1] && fall));
    assign drive[i] = cfg[i].mode inside {SCCU_CMP1, SCCU_CMP3, SCCU_DBL};
  end

  // Channel registers, configurations and once-per-period state.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        val[i] <= SCCU_CNT_RST;
        cfg[i] <= SCCU_CFG_RST;
      end
      armed <= '1;
      done <= '0;
      pin_q <= '0;
    end else begin
      pin_q <= pin_in;
      for (int i = 0; i < NCH; i++) begin
        // A capture wins over a software write in the same clock.
        if (cap_ev[i]) begin
          val[i] <= tb_ch[i];
        end else if (we_val[i]) begin
          val[i] <= wdata16;
        end
        // A new configuration restarts the one-shot and period gate.
        if (we_cfg[i]) begin
          cfg[i] <= sccu_cfg_type'(hwdata_in[6:0]);
          armed[i] <= 1'b1;
          done[i] <= 1'b0;
        end else begin
          if (match[i]) begin
            armed[i] <= 1'b0;
          end else if (ovf_ch[i]) begin
            armed[i] <= 1'b1;
          end
          if (match[i] && cfg[i].one_shot) begin
            done[i] <= 1'b1;
          end
        end
      end
    end
  end

  // Pin drive; compare mode zero and two leave the pin alone.
  // In mode three a match beats an overflow in the same clock, so a compare
  // value at the top count with a one-clock source sets the pin high in alternate periods only.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe_out <= '0;
    end else begin
      pin_oe_out <= drive;
      for (int i = 0; i < NCH; i++) begin
        if (cfg[i].mode == SCCU_CMP3 && match[i]) begin
          pin_out[i] <= 1'b1;
        end else if (cfg[i].mode == SCCU_CMP3 && ovf_ch[i]) begin
          pin_out[i] <= 1'b0;
        end else if (tog[i]) begin
          pin_out[i] <= !pin_out[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags.

  // Each channel flag covers both its captures and its matches.
  // A paired partner's flag still reports the partner's own matches.
  // The mask only gates the output; flags collect events regardless.
  wire [17:0] stat_set = {ovf, cap_ev | match};

  // Flags clear by writing one; a new event in the same clock wins.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stat <= SCCU_STAT_RST;
      mask <= SCCU_STAT_RST;
      irq_out <= 1'b0;
    end else begin
      stat <= (stat & ~(we_stat ? hwdata_in[17:0] : 18'h00000)) | stat_set;
      mask <= we_mask ? hwdata_in[17:0] : mask;
      irq_out <= |(stat & mask);
    end
  end

endmodule : sccu_top

// [logic/sccu_pkg.sv]
// Package of constants, register map and types for the capture/compare unit.
package sccu_pkg;

  // Number of channels and time bases.
  localparam int SCCU_NCH = 16;
  localparam int SCCU_NTB = 2;
  // Half of the channels; the low half may pair with the high half.
  localparam int SCCU_HALF = 8;

  // Byte offsets of the register map (address bits 7:0).
  localparam logic [7:0] SCCU_CTRL_OFS = 8'h00;
  localparam logic [7:0] SCCU_TB_OFS = 8'h04;
  localparam logic [7:0] SCCU_REL_OFS = 8'h0c;
  localparam logic [7:0] SCCU_STAT_OFS = 8'h14;
  localparam logic [7:0] SCCU_MASK_OFS = 8'h18;
  // Channel value and channel configuration windows (bits 7:6).
  localparam logic [1:0] SCCU_VAL_WIN = 2'h1;
  localparam logic [1:0] SCCU_CFG_WIN = 2'h2;

  // Control register field positions.
  localparam int SCCU_RUN_POS = 0;
  localparam int SCCU_STAG_POS = 2;
  localparam int SCCU_SEL_A_POS = 4;
  localparam int SCCU_SEL_B_POS = 8;
  // Status bit position of the first time-base overflow flag.
  localparam int SCCU_OVF_POS = 16;

  // Reset values and the top count.
  localparam logic [15:0] SCCU_CNT_RST = 16'h0000;
  localparam logic [2:0] SCCU_SEL_RST = 3'h0;
  localparam logic [17:0] SCCU_STAT_RST = 18'h00000;
  localparam logic [15:0] SCCU_CNT_TOP = 16'hffff;

  // Count source codes; codes below SCCU_SRC_NEIGH divide by 2**code.
  localparam logic [2:0] SCCU_SRC_NEIGH = 3'h6;
  localparam logic [2:0] SCCU_SRC_EXT = 3'h7;

  // Staggered option: one count slot in every eight clocks.
  localparam logic [2:0] SCCU_STAG_LAST = 3'h7;

  // Channel operating modes.
  typedef enum logic [2:0] {
    SCCU_OFF, SCCU_CAPT, SCCU_CMP0, SCCU_CMP1, SCCU_CMP2, SCCU_CMP3, SCCU_DBL
  } sccu_mode_type;

  // Capture edge selection; bit 0 rising, bit 1 falling.
  typedef enum logic [1:0] {
    SCCU_EDGE_NONE, SCCU_EDGE_RISE, SCCU_EDGE_FALL, SCCU_EDGE_BOTH
  } sccu_edge_type;

  // Per-channel configuration word, bits 6:0 of the channel config register.
  typedef struct packed {
    logic one_shot;
    sccu_edge_type edge_sel;
    logic tb_sel;
    sccu_mode_type mode;
  } sccu_cfg_type;

  localparam sccu_cfg_type SCCU_CFG_RST = '{1'b0, SCCU_EDGE_NONE, 1'b0, SCCU_OFF};

endpackage : sccu_pkg

// [sim/sccu_top_checker.sv]
// Port-level assertions for the capture/compare unit.
module sccu_top_checker #(
  parameter int NCH = 16 // Channel count.
) (
  input wire logic clk_in, // System clock.
  input wire logic rst_n_in, // Reset, active low.
  input wire logic hsel_in, // Bus select.
  input wire logic [1:0] htrans_in, // Transfer type.
  input wire logic hwrite_in, // Write flag.
  input wire logic hready_in, // Bus ready.
  input wire logic [31:0] hrdata_out, // Read data.
  input wire logic hreadyout_out, // Slave ready.
  input wire logic hresp_out, // Response.
  input wire logic [NCH-1:0] pin_in, // Pin levels.
  input wire logic [NCH-1:0] pin_out, // Pin drive.
  input wire logic [NCH-1:0] pin_oe_out, // Pin enables.
  input wire logic irq_out // Interrupt.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] rel_cnt; // Edges since release, saturating at three.
  logic rd_dp; // High in a read data phase.
  logic [4:0] wr_hist; // Writes taken in the last five edges.
  wire take = hsel_in & hready_in & htrans_in[1]; // Address phase accepted.
  //////////////////////////////////////////////////////////////////////////////
  // Bookkeeping; the write history covers register and output latency.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rel_cnt <= 2'h0;
      rd_dp <= 1'b0;
      wr_hist <= 5'h00;
    end else begin
      rel_cnt <= (rel_cnt == 2'h3) ? rel_cnt : rel_cnt + 2'h1;
      rd_dp <= take & ~hwrite_in;
      wr_hist <= {wr_hist[3:0], take & hwrite_in};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  resp_okay_a: assert property (hresp_out == 1'b0) else $error("error response seen");
  ready_early_a: assert property (rel_cnt < 2'h3 |-> !hreadyout_out && pin_oe_out == '0
    && !irq_out) else $error("outputs active too early after reset");
  ready_late_a: assert property (rel_cnt == 2'h3 |-> hreadyout_out)
    else $error("slave not ready");
  ready_stay_a: assert property (rel_cnt == 2'h3 |=> hreadyout_out [*3])
    else $error("wait state inserted");
  rdata_idle_a: assert property (!rd_dp |-> hrdata_out == 32'h0)
    else $error("read data outside data phase");
  irq_fall_a: assert property ($fell(irq_out) |-> wr_hist != 5'h00)
    else $error("interrupt dropped without a write");
  oe_change_a: assert property ($changed(pin_oe_out) |-> wr_hist != 5'h00)
    else $error("pin direction changed without a write");
  pin_hold_a: assert property (((pin_out ^ $past(pin_out)) & ~pin_oe_out
    & ~$past(pin_oe_out)) == '0) else $error("undriven pin value moved");
  cover property ($rose(pin_in[1]));
  cover property ($changed(pin_out));
  cover property ($rose(irq_out));
  cover property ($fell(irq_out));
endmodule : sccu_top_checker

bind sccu_top sccu_top_checker #(.NCH(NCH)) sccu_top_checker_inst (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
  .irq_out(irq_out));

// [sim/sccu_pins.sv]
// Model of the port pins around the unit.
module sccu_pins
  import sccu_pkg::*;
(
  input wire logic [SCCU_NCH-1:0] pin_out_in, // Unit drive values.
  input wire logic [SCCU_NCH-1:0] pin_oe_in, // Unit drive enables.
  input wire logic [SCCU_NCH-1:0] lvl_in, // Level applied from outside.
  output logic [SCCU_NCH-1:0] pin_in_out // Resolved pin levels.
);
  timeunit 1ns;
  timeprecision 100ps;
  // A driven pin reads back its own value; an input pin shows the outside level.
  assign pin_in_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & lvl_in);
endmodule : sccu_pins

// [sim/testbench.sv]
// Self-checking bench for the capture/compare unit.
module testbench;
  import sccu_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, ext_count_in = 1'b0;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, d;
  logic [1:0] htrans_in = 2'h0;
  logic hreadyout_out, hresp_out, irq_out;
  logic neighbour_ovf_in = 1'b0;
  logic [15:0] pin_in, pin_out, pin_oe_out, lvl = 16'h0000;
  int err_total = 0, n_tests = 0;
  sccu_top sccu_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .neighbour_ovf_in(neighbour_ovf_in),
    .ext_count_in(ext_count_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .irq_out(irq_out));
  sccu_pins sccu_pins_inst (.pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .lvl_in(lvl),
    .pin_in_out(pin_in));
  always #12.5 clk_in = ~clk_in; // 40 MHz.
  //////////////////////////////////////////////////////////////////////////////
  // Bus access: hold each phase until ready is sampled high.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rdv);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'h2;
    hwrite_in <= w;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    rdv = hrdata_out;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(a, 1'b1, wd, dummy);
  endtask : wr
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Bounded wait for a pin level, then compare it.
  task automatic wait_pin(input int i, input logic v);
    int k;
    k = 0;
    while (pin_out[i] !== v && k < 300) begin
      @(posedge clk_in);
      k++;
    end
    chk("pin level", {31'h0, v}, {31'h0, pin_out[i]});
  endtask : wait_pin
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs under two thousand clocks.
  initial begin
    #(25 * 20000);
    err_total++;
    $display("unexpected timeout");
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    xfer(SCCU_CTRL_OFS, 1'b0, 32'h0, d);
    chk("control", 32'h0, d);
    xfer(8'h30, 1'b0, 32'h0, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
    // Toggle compare on channel 0, time base A counting every clock.
    wr(8'h40, 32'h10);
    wr(8'h80, 32'h3);
    wr(SCCU_MASK_OFS, 32'h1);
    wr(SCCU_CTRL_OFS, 32'h1);
    wait_pin(0, 1'b1);
    chk("drive enable", 32'h1, {31'h0, pin_oe_out[0]});
    xfer(SCCU_STAT_OFS, 1'b0, 32'h0, d);
    chk("status", 32'h1, d);
    chk("irq", 32'h1, {31'h0, irq_out});
    wr(SCCU_STAT_OFS, 32'h1);
    wr(SCCU_CTRL_OFS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq_out});
    $display("test toggle done");
    // Set on match, clear on overflow; restart from the reload value.
    wr(SCCU_REL_OFS, 32'h1000);
    wr(8'h48, 32'hfff8);
    wr(8'h88, 32'h5);
    wr(SCCU_TB_OFS, 32'hfff0);
    wr(SCCU_CTRL_OFS, 32'h1);
    wait_pin(2, 1'b1);
    wait_pin(2, 1'b0);
    wr(SCCU_CTRL_OFS, 32'h0);
    xfer(SCCU_TB_OFS, 1'b0, 32'h0, d);
    chk("restart", 32'h100, {20'h0, d[15:4]});
    xfer(SCCU_STAT_OFS, 1'b0, 32'h0, d);
    chk("status", 32'h10004, d);
    $display("test overflow done");
    // Capture on channel 1 from time base B, both edges then falling only.
    wr(SCCU_STAT_OFS, 32'h3ffff);
    wr(8'h08, 32'habc);
    wr(8'h84, 32'h39);
    lvl[1] <= 1'b1;
    repeat (2) @(posedge clk_in);
    xfer(8'h44, 1'b0, 32'h0, d);
    chk("capture", 32'habc, d);
    xfer(SCCU_STAT_OFS, 1'b0, 32'h0, d);
    chk("status", 32'h2, d);
    wr(8'h08, 32'hdef);
    lvl[1] <= 1'b0;
    repeat (2) @(posedge clk_in);
    xfer(8'h44, 1'b0, 32'h0, d);
    chk("capture", 32'hdef, d);
    wr(8'h84, 32'h29);
    wr(8'h08, 32'h222);
    lvl[1] <= 1'b1;
    repeat (2) @(posedge clk_in);
    xfer(8'h44, 1'b0, 32'h0, d);
    chk("capture", 32'hdef, d);
    lvl[1] <= 1'b0;
    repeat (2) @(posedge clk_in);
    xfer(8'h44, 1'b0, 32'h0, d);
    chk("capture", 32'h222, d);
    $display("test capture done");
    // External count input advances time base B.
    wr(8'h08, 32'h100);
    wr(SCCU_CTRL_OFS, 32'h702);
    repeat (3) begin
      ext_count_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      ext_count_in <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
    wr(SCCU_CTRL_OFS, 32'h0);
    xfer(8'h08, 1'b0, 32'h0, d);
    chk("count", 32'h103, d);
    $display("test external count done");
    // Sources on time base B: neighbour pulses, then staggered divide by two.
    wr(8'h08, 32'h0);
    wr(SCCU_CTRL_OFS, 32'h602);
    neighbour_ovf_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    neighbour_ovf_in <= 1'b0;
    wr(SCCU_CTRL_OFS, 32'h0);
    xfer(8'h08, 1'b0, 32'h0, d);
    chk("count", 32'h3, d);
    wr(8'h08, 32'h0);
    wr(SCCU_CTRL_OFS, 32'h106);
    repeat (157) @(posedge clk_in); // With the stop access, 160 clocks of counting.
    wr(SCCU_CTRL_OFS, 32'h0);
    xfer(8'h08, 1'b0, 32'h0, d);
    chk("count", 32'ha, d);
    $display("test sources done");
    // Compare modes on time base A with a sixteen-count period.
    wr(8'h88, 32'h0);
    wr(SCCU_STAT_OFS, 32'h3ffff);
    wr(SCCU_REL_OFS, 32'hfff0);
    wr(8'h4c, 32'hfff2);
    wr(8'h50, 32'hfff2);
    wr(8'h54, 32'hfff4);
    wr(8'h58, 32'hfffc);
    wr(8'h74, 32'hfffe);
    wr(8'h8c, 32'h2);
    wr(8'h90, 32'h4);
    wr(8'h94, 32'h6);
    wr(8'h98, 32'h43);
    wr(SCCU_TB_OFS, 32'hfff0);
    wr(SCCU_CTRL_OFS, 32'h1);
    repeat (40) @(posedge clk_in);
    wr(SCCU_CTRL_OFS, 32'h0);
    xfer(SCCU_STAT_OFS, 1'b0, 32'h0, d);
    chk("status", 32'h12078, d);
    chk("drive enable", 32'h0, {30'h0, pin_oe_out[4:3]});
    chk("paired pin", 32'h1, {31'h0, pin_out[5]});
    chk("one-shot pin", 32'h1, {31'h0, pin_out[6]});
    // Rewind inside the period: mode zero matches again, mode two does not.
    wr(SCCU_STAT_OFS, 32'h3ffff);
    wr(SCCU_TB_OFS, 32'hfff0);
    wr(SCCU_CTRL_OFS, 32'h1);
    repeat (4) @(posedge clk_in);
    chk("paired pin", 32'h1, {31'h0, pin_out[5]});
    repeat (2) @(posedge clk_in);
    chk("paired pin", 32'h0, {31'h0, pin_out[5]});
    wr(SCCU_CTRL_OFS, 32'h0);
    xfer(SCCU_STAT_OFS, 1'b0, 32'h0, d);
    chk("status", 32'h28, d);
    $display("test modes done");
    end_of_test();
  end
endmodule : testbench
